// ---- rtl/tbac_consts.svh ----
`ifndef TBAC_CONSTS_SVH
`define TBAC_CONSTS_SVH

// Byte locations on the 8-bit bus
`define TBAC_OFF_CTRL_A 4'h0
`define TBAC_OFF_CTRL_B 4'h1
`define TBAC_OFF_FLAGS 4'h2
`define TBAC_OFF_CNT_L 4'h4
`define TBAC_OFF_CNT_H 4'h5
`define TBAC_OFF_CMPA_L 4'h6
`define TBAC_OFF_CMPC_H 4'hb
`define TBAC_OFF_CAP_L 4'hc
`define TBAC_OFF_CAP_H 4'hd

// Field positions
`define TBAC_WGM_LO_LSB 0
`define TBAC_WGM_HI_LSB 3
`define TBAC_FLAG_OVF 0

// Reset values
`define TBAC_RST_BYTE 8'h00
`define TBAC_RST_WORD 16'h0000

// Clock source select codes
`define TBAC_CS_STOP 3'h0
`define TBAC_CS_DIV1 3'h1
`define TBAC_CS_DIV8 3'h2
`define TBAC_CS_DIV64 3'h3
`define TBAC_CS_DIV256 3'h4
`define TBAC_CS_DIV1024 3'h5
`define TBAC_CS_EXT_FALL 3'h6
`define TBAC_CS_EXT_RISE 3'h7

// Fixed count values
`define TBAC_MAX 16'hffff
`define TBAC_ZERO_COUNT_INDICATION 16'h0000
`define TBAC_TOP_8 16'h00ff
`define TBAC_TOP_9 16'h01ff
`define TBAC_TOP_10 16'h03ff

// Waveform mode codes
`define TBAC_WGM_NORMAL 4'h0
`define TBAC_WGM_PC8 4'h1
`define TBAC_WGM_PC9 4'h2
`define TBAC_WGM_PC10 4'h3
`define TBAC_WGM_CTC_A 4'h4
`define TBAC_WGM_FAST8 4'h5
`define TBAC_WGM_FAST9 4'h6
`define TBAC_WGM_FAST10 4'h7
`define TBAC_WGM_PFC_I 4'h8
`define TBAC_WGM_PFC_A 4'h9
`define TBAC_WGM_PC_I 4'ha
`define TBAC_WGM_PC_A 4'hb
`define TBAC_WGM_CTC_I 4'hc
`define TBAC_WGM_FAST_I 4'he
`define TBAC_WGM_FAST_A 4'hf

// Prescaler width
`define TBAC_PRE_W 10

`endif

// ---- rtl/tbac_pkg.sv ----
package tbac_pkg;
   typedef logic [7:0] tbac_byte_t;
   typedef logic [15:0] tbac_word_t;
   typedef logic [3:0] tbac_mode_t;
   typedef logic [2:0] tbac_cs_t;
   typedef logic [3:0] tbac_addr_t;
   // What the counter does on a cycle
   typedef enum {TBAC_ACT_HOLD, TBAC_ACT_LOAD, TBAC_ACT_CLEAR, TBAC_ACT_STEP} tbac_act_t;
endpackage

// ---- rtl/tbac_tick_sel.sv ----
`timescale 1ns/10ps
`include "tbac_consts.svh"

module tbac_tick_sel #(
   parameter int PRE_W = `TBAC_PRE_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire tbac_pkg::tbac_cs_t cs,
   input wire logic ext_pin,
   output logic tick
);
   import tbac_pkg::*;

   logic ext_s1_r, ext_s1_nxt; // First sync stage, read by stage two only
   logic ext_s2_r, ext_s2_nxt; // Second sync stage
   logic ext_prev_r, ext_prev_nxt; // Previous synced level for edges
   logic [PRE_W-1:0] pre_r, pre_nxt; // Free-running prescaler

   // Next values and tick select
   always_comb begin
      ext_s1_nxt = ext_pin;
      ext_s2_nxt = ext_s1_r;
      ext_prev_nxt = ext_s2_r;
      pre_nxt = pre_r + 1'b1;
      unique case (cs)
         `TBAC_CS_STOP: tick = 1'b0; // No source, timer stopped
         `TBAC_CS_DIV1: tick = 1'b1;
         `TBAC_CS_DIV8: tick = &pre_r[2:0];
         `TBAC_CS_DIV64: tick = &pre_r[5:0];
         `TBAC_CS_DIV256: tick = &pre_r[7:0];
         `TBAC_CS_DIV1024: tick = &pre_r[9:0];
         `TBAC_CS_EXT_FALL: tick = ext_prev_r & ~ext_s2_r;
         `TBAC_CS_EXT_RISE: tick = ~ext_prev_r & ext_s2_r;
      endcase
   end

   // Registers only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_prev_r <= 1'b0;
         pre_r <= '0;
      end else begin
         ext_s1_r <= ext_s1_nxt;
         ext_s2_r <= ext_s2_nxt;
         ext_prev_r <= ext_prev_nxt;
         pre_r <= pre_nxt;
      end
   end
endmodule

// ---- rtl/tbac_count_unit.sv ----
`timescale 1ns/10ps
`include "tbac_consts.svh"

module tbac_count_unit (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire tbac_pkg::tbac_mode_t mode,
   input wire tbac_pkg::tbac_word_t cmp_a,
   input wire tbac_pkg::tbac_word_t cap,
   input wire logic load,
   input wire tbac_pkg::tbac_word_t load_val,
   output tbac_pkg::tbac_word_t count,
   output logic top_hit,
   output logic ovf_evt
);
   import tbac_pkg::*;

   tbac_word_t count_r, count_nxt; // The 16-bit counter
   logic up_r, up_nxt; // Direction for dual-slope modes
   tbac_word_t top_val; // Highest value of the sequence
   logic dual; // Up then down counting
   logic ctc; // Clear on top, overflow at MAX
   tbac_act_t act; // Chosen action this cycle

   // Top selection by mode
   always_comb begin
      dual = 1'b0;
      ctc = 1'b0;
      unique case (mode)
         `TBAC_WGM_PC8, `TBAC_WGM_FAST8: top_val = `TBAC_TOP_8;
         `TBAC_WGM_PC9, `TBAC_WGM_FAST9: top_val = `TBAC_TOP_9;
         `TBAC_WGM_PC10, `TBAC_WGM_FAST10: top_val = `TBAC_TOP_10;
         `TBAC_WGM_PFC_A, `TBAC_WGM_PC_A, `TBAC_WGM_FAST_A, `TBAC_WGM_CTC_A: top_val = cmp_a;
         `TBAC_WGM_PFC_I, `TBAC_WGM_PC_I, `TBAC_WGM_FAST_I, `TBAC_WGM_CTC_I: top_val = cap;
         default: top_val = `TBAC_MAX; // Normal and the reserved code
      endcase
      unique case (mode)
         `TBAC_WGM_PC8, `TBAC_WGM_PC9, `TBAC_WGM_PC10: dual = 1'b1;
         `TBAC_WGM_PFC_I, `TBAC_WGM_PFC_A, `TBAC_WGM_PC_I, `TBAC_WGM_PC_A: dual = 1'b1;
         `TBAC_WGM_NORMAL, `TBAC_WGM_CTC_A, `TBAC_WGM_CTC_I: ctc = 1'b1;
         default: dual = 1'b0;
      endcase
   end

   // Action and next count; a bus load beats any tick
   always_comb begin
      count_nxt = count_r;
      up_nxt = up_r;
      top_hit = (count_r == top_val);
      ovf_evt = 1'b0;
      if (load) begin
         act = TBAC_ACT_LOAD;
      end else if (!tick) begin
         act = TBAC_ACT_HOLD;
      end else if (!dual && count_r >= top_val) begin
         act = TBAC_ACT_CLEAR; // Also recovers if top moved below count
      end else begin
         act = TBAC_ACT_STEP;
      end
      unique case (act)
         TBAC_ACT_LOAD: count_nxt = load_val;
         TBAC_ACT_HOLD: count_nxt = count_r;
         TBAC_ACT_CLEAR: begin
            count_nxt = `TBAC_ZERO_COUNT_INDICATION;
            ovf_evt = ctc ? (count_r == `TBAC_MAX) : 1'b1;
         end
         TBAC_ACT_STEP: begin
            if (dual && up_r && count_r >= top_val) begin
               up_nxt = 1'b0;
            end else if (dual && !up_r && count_r == `TBAC_ZERO_COUNT_INDICATION) begin
               up_nxt = 1'b1;
               ovf_evt = 1'b1; // Dual slope overflows at zero_count_indication
            end
            if (!dual || up_nxt) begin
               count_nxt = count_r + 16'h0001;
            end else begin
               count_nxt = count_r - 16'h0001;
            end
         end
      endcase
   end

   // Registers only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_r <= `TBAC_RST_WORD;
         up_r <= 1'b1;
      end else begin
         count_r <= count_nxt;
         up_r <= up_nxt;
      end
   end

   assign count = count_r;
endmodule

// ---- rtl/tbac_timer.sv ----
`timescale 1ns/10ps
`include "tbac_consts.svh"

// Contract
// - One 8-bit holding register per timer
// - Holding register shared by all wide registers
// - Low-byte write loads holding plus data
// - Low-byte read copies upper byte to holding
// - Compare reads bypass the holding register
// - One upper write serves several lower writes
// - Clock select zero stops the counter
// - Counter clears, increments or decrements per tick
// - Indicate TOP at the mode's top value, ZERO_COUNT_INDICATION at zero
// - Counter accessible whether or not ticking
// - Bus write beats clear or count
// - Four-bit mode field split across controls
// - Overflow flag set where mode defines
// - Upper counter location reaches holding register
// - Maximum all ones, zero_count_indication all zeros
// - TOP fixed 8/9/10 bit, compare A, capture
module tbac_timer (
   input wire logic CLK,
   input wire logic RST_N,
   input wire tbac_pkg::tbac_addr_t ADDR,
   input wire logic WR_EN,
   input wire logic RD_EN,
   input wire tbac_pkg::tbac_byte_t WDATA,
   input wire logic EXT_COUNT_PIN,
   output tbac_pkg::tbac_byte_t RDATA,
   output logic TOP_INDICATION,
   output logic ZERO_COUNT_INDICATION,
   output logic OVERFLOW_FLAG
);
   import tbac_pkg::*;

   tbac_byte_t ctrl_a_r, ctrl_a_nxt; // timer_control_a
   tbac_byte_t ctrl_b_r, ctrl_b_nxt; // timer_control_b
   tbac_byte_t hold_r, hold_nxt; // Shared upper-byte holding register
   tbac_word_t cmp_r [3]; // compare_value_regs A, B, C
   tbac_word_t cmp_nxt [3];
   tbac_word_t cap_r, cap_nxt; // capture_value_reg
   logic ovf_r, ovf_nxt; // overflow_flag
   tbac_byte_t rdata_r, rdata_nxt; // Registered read answer
   logic top_ind_r, top_ind_nxt;
   logic zero_ind_r, zero_ind_nxt;

   tbac_mode_t wave_mode; // waveform_mode_field
   tbac_cs_t clock_source_select;
   logic timer_tick; // One-cycle tick from the source select
   tbac_word_t count_value;
   logic cnt_load; // Bus write to the counter low byte
   logic top_hit;
   logic ovf_evt;
   logic wr_lo;
   logic wr_hi;
   logic rd_lo;
   logic cap_writable;

   // Low locations are even, high locations odd, from the counter upward
   function automatic logic is_wide(input tbac_addr_t a);
      is_wide = (a >= `TBAC_OFF_CNT_L) && (a <= `TBAC_OFF_CAP_H);
   endfunction

   // Compare slot of a byte location
   function automatic logic [1:0] cmp_idx(input tbac_addr_t a);
      tbac_addr_t d;
      d = a - `TBAC_OFF_CMPA_L;
      cmp_idx = d[2:1];
   endfunction

   // Location is one of the compare bytes
   function automatic logic is_cmp(input tbac_addr_t a);
      is_cmp = (a >= `TBAC_OFF_CMPA_L) && (a <= `TBAC_OFF_CMPC_H);
   endfunction

   // Mode field split across both controls
   assign wave_mode = {ctrl_b_r[`TBAC_WGM_HI_LSB +: 2], ctrl_a_r[`TBAC_WGM_LO_LSB +: 2]};
   assign clock_source_select = ctrl_b_r[2:0];
   assign wr_lo = WR_EN && is_wide(ADDR) && !ADDR[0];
   assign wr_hi = WR_EN && is_wide(ADDR) && ADDR[0];
   assign rd_lo = RD_EN && !WR_EN && is_wide(ADDR) && !ADDR[0];
   assign cnt_load = wr_lo && ADDR == `TBAC_OFF_CNT_L;
   // Capture is only writable while it defines top
   assign cap_writable = (wave_mode == `TBAC_WGM_PFC_I) || (wave_mode == `TBAC_WGM_PC_I)
      || (wave_mode == `TBAC_WGM_CTC_I) || (wave_mode == `TBAC_WGM_FAST_I);

   tbac_tick_sel #(
      .PRE_W(`TBAC_PRE_W)
   ) u_tick (
      .clk(CLK),
      .rst_n(RST_N),
      .cs(clock_source_select),
      .ext_pin(EXT_COUNT_PIN),
      .tick(timer_tick)
   );

   // Holding plus written byte form the loaded value
   tbac_count_unit u_count (
      .clk(CLK),
      .rst_n(RST_N),
      .tick(timer_tick),
      .mode(wave_mode),
      .cmp_a(cmp_r[0]),
      .cap(cap_r),
      .load(cnt_load),
      .load_val({hold_r, WDATA}),
      .count(count_value),
      .top_hit(top_hit),
      .ovf_evt(ovf_evt)
   );

   // Bus writes to control, compare, capture and the holding register
   always_comb begin
      ctrl_a_nxt = ctrl_a_r;
      ctrl_b_nxt = ctrl_b_r;
      hold_nxt = hold_r;
      cap_nxt = cap_r;
      for (int i = 0; i < 3; i++) begin
         cmp_nxt[i] = cmp_r[i];
      end
      if (WR_EN && ADDR == `TBAC_OFF_CTRL_A) begin
         ctrl_a_nxt = WDATA;
      end
      if (WR_EN && ADDR == `TBAC_OFF_CTRL_B) begin
         ctrl_b_nxt = WDATA;
      end
      if (wr_hi) begin
         hold_nxt = WDATA; // Only the holding register changes
      end else if (rd_lo && !is_cmp(ADDR)) begin
         // Upper byte latched as the low byte goes out
         hold_nxt = (ADDR == `TBAC_OFF_CAP_L) ? cap_r[15:8] : count_value[15:8];
      end
      if (wr_lo && is_cmp(ADDR)) begin
         cmp_nxt[cmp_idx(ADDR)] = {hold_r, WDATA}; // Holding reused freely
      end
      if (wr_lo && ADDR == `TBAC_OFF_CAP_L && cap_writable) begin
         cap_nxt = {hold_r, WDATA};
      end
   end

   // Status: set wins over a write-one clear
   always_comb begin
      ovf_nxt = ovf_r;
      if (WR_EN && ADDR == `TBAC_OFF_FLAGS && WDATA[`TBAC_FLAG_OVF]) begin
         ovf_nxt = 1'b0;
      end
      if (ovf_evt) begin
         ovf_nxt = 1'b1;
      end
      top_ind_nxt = top_hit;
      zero_ind_nxt = (count_value == `TBAC_ZERO_COUNT_INDICATION);
   end

   // Read answer, one cycle after the strobe; unmapped reads zero
   always_comb begin
      rdata_nxt = rdata_r;
      if (RD_EN && !WR_EN) begin
         if (is_cmp(ADDR)) begin
            // Compare bytes straight out
            rdata_nxt = ADDR[0] ? cmp_r[cmp_idx(ADDR)][15:8] : cmp_r[cmp_idx(ADDR)][7:0];
         end else if (is_wide(ADDR) && ADDR[0]) begin
            rdata_nxt = hold_r; // Upper counter and capture locations
         end else if (ADDR == `TBAC_OFF_CNT_L) begin
            rdata_nxt = count_value[7:0];
         end else if (ADDR == `TBAC_OFF_CAP_L) begin
            rdata_nxt = cap_r[7:0];
         end else if (ADDR == `TBAC_OFF_CTRL_A) begin
            rdata_nxt = ctrl_a_r;
         end else if (ADDR == `TBAC_OFF_CTRL_B) begin
            rdata_nxt = ctrl_b_r;
         end else if (ADDR == `TBAC_OFF_FLAGS) begin
            rdata_nxt = {7'h00, ovf_r};
         end else begin
            rdata_nxt = 8'h00;
         end
      end
   end

   // Registers only; reset leaves the timer stopped
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctrl_a_r <= `TBAC_RST_BYTE;
         ctrl_b_r <= `TBAC_RST_BYTE;
         hold_r <= `TBAC_RST_BYTE;
         cap_r <= `TBAC_RST_WORD;
         for (int i = 0; i < 3; i++) begin
            cmp_r[i] <= `TBAC_RST_WORD;
         end
         ovf_r <= 1'b0;
         rdata_r <= `TBAC_RST_BYTE;
         top_ind_r <= 1'b0;
         zero_ind_r <= 1'b0;
      end else begin
         ctrl_a_r <= ctrl_a_nxt;
         ctrl_b_r <= ctrl_b_nxt;
         hold_r <= hold_nxt;
         cap_r <= cap_nxt;
         for (int i = 0; i < 3; i++) begin
            cmp_r[i] <= cmp_nxt[i];
         end
         ovf_r <= ovf_nxt;
         rdata_r <= rdata_nxt;
         top_ind_r <= top_ind_nxt;
         zero_ind_r <= zero_ind_nxt;
      end
   end

   assign RDATA = rdata_r;
   assign TOP_INDICATION = top_ind_r;
   assign ZERO_COUNT_INDICATION = zero_ind_r;
   assign OVERFLOW_FLAG = ovf_r;

   // Checks
   property p_hi_write_hold;
      @(posedge CLK) disable iff (!RST_N)
      (WR_EN && ADDR == `TBAC_OFF_CNT_H) |=> hold_r == $past(WDATA);
   endproperty
   a_hi_write_hold: assert property (p_hi_write_hold) else $error("upper write missed");

   property p_lo_write_load;
      @(posedge CLK) disable iff (!RST_N)
      (WR_EN && ADDR == `TBAC_OFF_CNT_L) |=> count_value == {$past(hold_r), $past(WDATA)};
   endproperty
   a_lo_write_load: assert property (p_lo_write_load) else $error("counter load wrong");

   property p_lo_read;
      @(posedge CLK) disable iff (!RST_N)
      (RD_EN && !WR_EN && ADDR == `TBAC_OFF_CNT_L)
      |=> hold_r == $past(count_value[15:8]) && RDATA == $past(count_value[7:0]);
   endproperty
   a_lo_read: assert property (p_lo_read) else $error("low read pairing wrong");

   property p_cmp_read;
      @(posedge CLK) disable iff (!RST_N)
      (RD_EN && !WR_EN && ADDR == `TBAC_OFF_CMPA_L + 4'h1)
      |=> RDATA == $past(cmp_r[0][15:8]) && $stable(hold_r);
   endproperty
   a_cmp_read: assert property (p_cmp_read) else $error("compare read used holding");

   property p_cap_hi_read;
      @(posedge CLK) disable iff (!RST_N)
      (RD_EN && !WR_EN && ADDR == `TBAC_OFF_CAP_H) |=> RDATA == $past(hold_r);
   endproperty
   a_cap_hi_read: assert property (p_cap_hi_read) else $error("capture upper read wrong");

   property p_stopped;
      @(posedge CLK) disable iff (!RST_N)
      (clock_source_select == `TBAC_CS_STOP && !cnt_load) |=> $stable(count_value);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

   property p_cmp_multi;
      @(posedge CLK) disable iff (!RST_N)
      (WR_EN && ADDR == `TBAC_OFF_CMPA_L + 4'h2) ##1 (WR_EN && ADDR == `TBAC_OFF_CMPA_L + 4'h4)
      |=> cmp_r[1][15:8] == cmp_r[2][15:8];
   endproperty
   a_cmp_multi: assert property (p_cmp_multi) else $error("shared upper byte lost");

   property p_zero_ind;
      @(posedge CLK) disable iff (!RST_N)
      (WR_EN && ADDR == `TBAC_OFF_CNT_L && hold_r == 8'h00 && WDATA == 8'h00)
      |=> ##1 ZERO_COUNT_INDICATION;
   endproperty
   a_zero_ind: assert property (p_zero_ind) else $error("zero indication missing");

   property p_ovf_set;
      @(posedge CLK) disable iff (!RST_N)
      ovf_evt |=> OVERFLOW_FLAG;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow lost");

   property p_cnt_hi_read;
      @(posedge CLK) disable iff (!RST_N)
      (RD_EN && !WR_EN && ADDR == `TBAC_OFF_CNT_H) |=> RDATA == $past(hold_r);
   endproperty
   a_cnt_hi_read: assert property (p_cnt_hi_read) else $error("upper read wrong");

   property p_ovf_clear;
      @(posedge CLK) disable iff (!RST_N)
      (WR_EN && ADDR == `TBAC_OFF_FLAGS && WDATA[`TBAC_FLAG_OVF] && !ovf_evt) |=> !OVERFLOW_FLAG;
   endproperty
   a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared");

   property p_top_ind;
      @(posedge CLK) disable iff (!RST_N)
      top_hit |=> TOP_INDICATION;
   endproperty
   a_top_ind: assert property (p_top_ind) else $error("top indication missing");

   // No disable: this one watches reset itself
   property p_reset_clear;
      @(posedge CLK)
      !RST_N |=> count_value == `TBAC_RST_WORD && hold_r == `TBAC_RST_BYTE
         && clock_source_select == `TBAC_CS_STOP;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

   c_ovf: cover property (@(posedge CLK) disable iff (!RST_N) ovf_evt);
   c_top: cover property (@(posedge CLK) disable iff (!RST_N) TOP_INDICATION);
   c_load_tick: cover property (@(posedge CLK) disable iff (!RST_N) cnt_load && timer_tick);
endmodule

// ---- dv/tbac_cpu_model.sv ----
`timescale 1ns/10ps
`include "tbac_consts.svh"

// Byte-wide processor core; each access is entered 1 ns after a rising edge
module tbac_cpu_model (
   input wire logic clk,
   output tbac_pkg::tbac_addr_t addr,
   output logic wr_en,
   output logic rd_en,
   output tbac_pkg::tbac_byte_t wdata,
   input wire tbac_pkg::tbac_byte_t rdata
);
   import tbac_pkg::*;

   // Quiet bus from time zero
   initial begin
      addr = 4'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      wdata = 8'h00;
   end

   // One byte write, held until the taking edge
   task automatic wr_byte(input tbac_addr_t a, input tbac_byte_t d);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      rd_en = 1'b0;
      @(posedge clk);
      #1;
   endtask

   // One byte read; answer is registered at the taking edge
   task automatic rd_byte(input tbac_addr_t a, output tbac_byte_t d);
      addr = a;
      wr_en = 1'b0;
      rd_en = 1'b1;
      @(posedge clk);
      #1;
      d = rdata;
   endtask

   // Strobes down; data line stops showing the old byte
   task automatic idle();
      wr_en = 1'b0;
      rd_en = 1'b0;
      wdata = ~wdata;
      @(posedge clk);
      #1;
   endtask

   // Upper first, then lower; no other access may slip in between
   task automatic wr16(input tbac_addr_t a, input tbac_word_t v);
      wr_byte(a + 4'h1, v[15:8]);
      wr_byte(a, v[7:0]);
      idle();
   endtask

   // Lower first, which latches the upper half of counter or capture, then upper
   task automatic rd16(input tbac_addr_t a, output tbac_word_t v);
      rd_byte(a, v[7:0]);
      rd_byte(a + 4'h1, v[15:8]);
      idle();
   endtask

   // Shared upper byte written once, then both lower bytes
   task automatic wr_pair(input tbac_addr_t a1, input tbac_addr_t a2, input tbac_word_t v1,
                          input tbac_word_t v2);
      wr_byte(a1 + 4'h1, v1[15:8]);
      wr_byte(a1, v1[7:0]);
      wr_byte(a2, v2[7:0]);
      idle();
   endtask
endmodule

// ---- dv/timer16_byte_access_counter_test.sv ----
`timescale 1ns/10ps
`include "tbac_consts.svh"

module timer16_byte_access_counter_test;
   import tbac_pkg::*;

   // Round-trip row: lower address, value written, value read back
   typedef struct packed {tbac_addr_t lo; tbac_word_t wval; tbac_word_t rexp;} tbac_rt_row_t;
   // Counting row: mode, its top, dual-slope or not, overflow expected
   typedef struct packed {tbac_mode_t mode; tbac_word_t top; logic dual; logic ovf;}
      tbac_md_row_t;

   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic EXT_COUNT_PIN = 1'b0;
   tbac_addr_t ADDR;
   logic WR_EN;
   logic RD_EN;
   tbac_byte_t WDATA;
   tbac_byte_t RDATA;
   logic TOP_INDICATION;
   logic ZERO_COUNT_INDICATION;
   logic OVERFLOW_FLAG;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   int k;
   tbac_word_t w;
   tbac_byte_t b;
   logic ok;
   // Capture write is refused in the normal mode, so it reads back zero
   tbac_rt_row_t rt_rows[5] = '{'{`TBAC_OFF_CNT_L, 16'h01ff, 16'h01ff},
      '{`TBAC_OFF_CMPA_L, 16'hbeef, 16'hbeef}, '{4'h8, 16'h8001, 16'h8001},
      '{4'ha, 16'hffff, 16'hffff}, '{`TBAC_OFF_CAP_L, 16'h5a5a, 16'h0000}};
   tbac_md_row_t md_rows[9] = '{'{`TBAC_WGM_NORMAL, `TBAC_MAX, 1'b0, 1'b1},
      '{`TBAC_WGM_FAST8, `TBAC_TOP_8, 1'b0, 1'b1}, '{`TBAC_WGM_FAST9, `TBAC_TOP_9, 1'b0, 1'b1},
      '{`TBAC_WGM_FAST10, `TBAC_TOP_10, 1'b0, 1'b1}, '{`TBAC_WGM_FAST_A, 16'h0300, 1'b0, 1'b1},
      '{`TBAC_WGM_FAST_I, 16'h0400, 1'b0, 1'b1}, '{`TBAC_WGM_CTC_A, 16'h0300, 1'b0, 1'b0},
      '{`TBAC_WGM_CTC_I, 16'h0400, 1'b0, 1'b0}, '{`TBAC_WGM_PC8, `TBAC_TOP_8, 1'b1, 1'b0}};
   tbac_cs_t ext_cs[2] = '{`TBAC_CS_EXT_FALL, `TBAC_CS_EXT_RISE};

   tbac_timer dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_EN(WR_EN), .RD_EN(RD_EN),
      .WDATA(WDATA), .EXT_COUNT_PIN(EXT_COUNT_PIN), .RDATA(RDATA),
      .TOP_INDICATION(TOP_INDICATION), .ZERO_COUNT_INDICATION(ZERO_COUNT_INDICATION),
      .OVERFLOW_FLAG(OVERFLOW_FLAG));

   tbac_cpu_model cpu (.clk(CLK), .addr(ADDR), .wr_en(WR_EN), .rd_en(RD_EN), .wdata(WDATA),
      .rdata(RDATA));

   // 200 MHz clock
   always #2.5 CLK = ~CLK;

   // Whole run needs well under a thousand cycles
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         $display("CHECK FAILED t=%0t run hung", $time);
         report_and_stop();
      end
   end

   // Four-state compare, counted
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Mode split over both controls; control B also carries the source
   task automatic set_ctrl(input tbac_mode_t m, input tbac_cs_t cs);
      cpu.wr_byte(`TBAC_OFF_CTRL_A, {6'h00, m[1:0]});
      cpu.wr_byte(`TBAC_OFF_CTRL_B, {3'h0, m[3:2], cs});
      cpu.idle();
   endtask

   task automatic report_and_stop();
      $display("summary: %0d compared, %0d mismatched", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      // Reset for four edges, then the state left behind
      repeat (4) @(posedge CLK);
      #1;
      RST_N = 1'b1;
      repeat (2) @(posedge CLK);
      #1;
      check({8'h00, RDATA}, 16'h0000, "reset answer");
      check({14'h0, TOP_INDICATION, OVERFLOW_FLAG}, 16'h0000, "reset flags");
      check({15'h0, ZERO_COUNT_INDICATION}, 16'h0001, "zero_count_indication at reset");
      cpu.rd_byte(`TBAC_OFF_CNT_H, b);
      check({8'h00, b}, 16'h0000, "holding at reset");
      cpu.rd_byte(`TBAC_OFF_CTRL_B, b);
      check({8'h00, b}, 16'h0000, "select at reset");
      cpu.rd16(`TBAC_OFF_CNT_L, w);
      check(w, 16'h0000, "counter at reset");
      $display("test reset done");

      // Ordinary round trips, counter stopped
      foreach (rt_rows[i]) begin
         cpu.wr16(rt_rows[i].lo, rt_rows[i].wval);
         cpu.rd16(rt_rows[i].lo, w);
         check(w, rt_rows[i].rexp, "round trip");
      end
      check({15'h0, ZERO_COUNT_INDICATION}, 16'h0000, "not at zero_count_indication");
      $display("test round trips done");

      // Upper write alone leaves the counter untouched
      cpu.wr_byte(`TBAC_OFF_CNT_H, 8'h12);
      cpu.idle();
      cpu.rd16(`TBAC_OFF_CNT_L, w);
      check(w, 16'h01ff, "upper write alone");
      cpu.wr_byte(`TBAC_OFF_CNT_H, 8'h34);
      cpu.rd_byte(`TBAC_OFF_CNT_H, b);
      check({8'h00, b}, 16'h0034, "upper reads holding");
      // Held upper byte lands in another register
      cpu.wr_byte(4'h8, 8'h56);
      cpu.idle();
      cpu.rd16(4'h8, w);
      check(w, 16'h3456, "shared holding");
      cpu.rd_byte(`TBAC_OFF_CNT_L, b);
      cpu.rd_byte(4'h7, b);
      check({8'h00, b}, 16'h00be, "compare upper direct");
      cpu.rd_byte(`TBAC_OFF_CMPA_L, b);
      cpu.rd_byte(`TBAC_OFF_CNT_H, b);
      check({8'h00, b}, 16'h0001, "holding kept");
      cpu.rd_byte(`TBAC_OFF_CAP_L, b);
      cpu.rd_byte(`TBAC_OFF_CNT_H, b);
      check({8'h00, b}, 16'h0000, "capture fills holding");
      cpu.rd_byte(4'he, b);
      check({8'h00, b}, 16'h0000, "unmapped read");
      cpu.wr_pair(4'h8, 4'ha, 16'h7711, 16'h7722);
      cpu.rd16(4'h8, w);
      check(w, 16'h7711, "pair first");
      cpu.rd16(4'ha, w);
      check(w, 16'h7722, "pair second");
      $display("test holding register done");

      // Nine of the modes from just below their top, every clock
      foreach (md_rows[i]) begin
         set_ctrl(md_rows[i].mode, `TBAC_CS_STOP);
         cpu.wr_byte(`TBAC_OFF_FLAGS, 8'h01);
         cpu.wr16(`TBAC_OFF_CMPA_L, md_rows[i].top);
         cpu.wr16(`TBAC_OFF_CAP_L, md_rows[i].top);
         cpu.wr16(`TBAC_OFF_CNT_L, md_rows[i].top - 16'h0003);
         check({15'h0, OVERFLOW_FLAG}, 16'h0000, "flag cleared");
         set_ctrl(md_rows[i].mode, `TBAC_CS_DIV1);
         for (k = 0; k < 40 && TOP_INDICATION !== 1'b1; k++) begin
            @(posedge CLK);
            #1;
         end
         check({15'h0, TOP_INDICATION}, 16'h0001, "top reached");
         repeat (6) @(posedge CLK);
         #1;
         set_ctrl(md_rows[i].mode, `TBAC_CS_STOP);
         cpu.rd16(`TBAC_OFF_CNT_L, w);
         // Fast modes wrap to zero_count_indication; dual slope turns and counts down
         if (md_rows[i].dual) begin
            ok = (w < md_rows[i].top) && (w > md_rows[i].top - 16'h0020);
         end else begin
            ok = (w < 16'h0020);
         end
         check({15'h0, ok}, 16'h0001, "count past top");
         check({15'h0, OVERFLOW_FLAG}, {15'h0, md_rows[i].ovf}, "overflow");
      end
      $display("test modes done");

      // Bus write while counting wins
      set_ctrl(`TBAC_WGM_NORMAL, `TBAC_CS_DIV1);
      cpu.wr16(`TBAC_OFF_CNT_L, 16'h1234);
      set_ctrl(`TBAC_WGM_NORMAL, `TBAC_CS_STOP);
      cpu.rd16(`TBAC_OFF_CNT_L, w);
      ok = (w >= 16'h1234) && (w < 16'h1240);
      check({15'h0, ok}, 16'h0001, "write while counting");
      $display("test write priority done");

      // Three pin edges of each kind give exactly three counts
      foreach (ext_cs[i]) begin
         cpu.wr16(`TBAC_OFF_CNT_L, 16'h0010);
         set_ctrl(`TBAC_WGM_NORMAL, ext_cs[i]);
         repeat (3) begin
            EXT_COUNT_PIN = 1'b1;
            repeat (4) @(posedge CLK);
            #1;
            EXT_COUNT_PIN = 1'b0;
            repeat (4) @(posedge CLK);
            #1;
         end
         repeat (6) @(posedge CLK);
         #1;
         set_ctrl(`TBAC_WGM_NORMAL, `TBAC_CS_STOP);
         cpu.rd16(`TBAC_OFF_CNT_L, w);
         check(w, 16'h0013, "pin edges");
      end
      // Stopped counter holds
      repeat (20) @(posedge CLK);
      #1;
      cpu.rd16(`TBAC_OFF_CNT_L, w);
      check(w, 16'h0013, "stopped holds");
      // Zero load shows zero_count_indication; divide by eight over 83 edges
      cpu.wr16(`TBAC_OFF_CNT_L, 16'h0000);
      check({15'h0, ZERO_COUNT_INDICATION}, 16'h0001, "zero load");
      set_ctrl(`TBAC_WGM_NORMAL, `TBAC_CS_DIV8);
      repeat (80) @(posedge CLK);
      #1;
      set_ctrl(`TBAC_WGM_NORMAL, `TBAC_CS_STOP);
      cpu.rd16(`TBAC_OFF_CNT_L, w);
      check({15'h0, w == 16'h000a || w == 16'h000b}, 16'h0001, "div8");
      $display("test clock sources done");
      // Reset in mid-run while counting
      cpu.wr_byte(`TBAC_OFF_CNT_H, 8'h5a);
      set_ctrl(`TBAC_WGM_FAST8, `TBAC_CS_DIV1);
      RST_N = 1'b0;
      repeat (2) @(posedge CLK);
      #1;
      RST_N = 1'b1;
      cpu.rd_byte(`TBAC_OFF_CNT_H, b);
      check({8'h00, b}, 16'h0000, "holding cleared");
      cpu.rd_byte(`TBAC_OFF_CTRL_B, b);
      check({8'h00, b}, 16'h0000, "select cleared");
      cpu.rd16(`TBAC_OFF_CNT_L, w);
      check(w, 16'h0000, "counter cleared");
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule
